//--- verilog/monitor_cal_defs.vh
/*
 * constants for the monitor calibration and alarm block: unit codes,
 * channel indices, calibration field widths and clamp values.
 * assumes inclusion by bare name from the design files.
 */
`ifndef MONITOR_CAL_DEFS_VH
`define MONITOR_CAL_DEFS_VH

// channel indices
`define CH_TEMP 3'h0
`define CH_SUPPLY 3'h1
`define CH_BIASMON 3'h2
`define CH_RXSTR 3'h3
`define CH_AUX1 3'h4
`define CH_AUX2 3'h5
`define CH_BMD 3'h6
`define NUM_CH 7
`define NUM_FLAGGED 6

// unit-selection codes for the auxiliary channels
`define UNIT_UNUSED 4'h0
`define UNIT_PD_BIAS 4'h1
`define UNIT_RESERVED 4'h2
`define UNIT_COOLER_I 4'h3
`define UNIT_LASER_TEMP 4'h4
`define UNIT_WAVELENGTH 4'h5
`define UNIT_SUPPLY_V_FIRST 4'h6
`define UNIT_SUPPLY_V_LAST 4'h9
`define UNIT_SUPPLY_I_FIRST 4'ha
`define UNIT_SUPPLY_I_GAP_LO 4'hb
`define UNIT_SUPPLY_I_GAP_HI 4'hc
`define UNIT_SUPPLY_I_LAST 4'hf

// unit class reported for an auxiliary channel
`define CLASS_UNUSED 3'h0
`define CLASS_VOLT_10MV 3'h1
`define CLASS_CURR_100UA 3'h2
`define CLASS_TEMP 3'h3
`define CLASS_WAVELENGTH 3'h4
`define CLASS_SUPPLY_V 3'h5
`define CLASS_INVALID 3'h6

// calibration arithmetic
`define GAIN_FRAC_BITS 15
`define RESULT_CLAMP 16'hfff8
`define RESULT_MAX 17'h0fff8
`define SHIFT_W 3
`define CONV_MASK 16'hfff8

// temperature clamp limits
`define TEMP_MAX 16'h7ff8
`define TEMP_MIN 16'h8800

`endif

//--- verilog/channel_calibrator.v
/*
 * one calibration path: gain, offset, clamp and optional right shift of a
 * 13-bit left-justified converter result.
 * assumes the sample strobe is one clock wide and settings are static.
 */
`timescale 1ns/1ps
`include "monitor_cal_defs.vh"

module channel_calibrator #(
  parameter HAS_GAIN = 1,
  parameter HAS_SHIFT = 1,
  parameter SIGNED_RESULT = 0
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // raw sample
  input wire sampleValid,
  input wire [15:0] rawSample,
  // calibration settings
  input wire [15:0] gain,
  input wire [15:0] offset,
  input wire [2:0] rightShift,
  // calibrated result
  output reg resultValid,
  output reg [15:0] result
);

  reg [31:0] product;
  reg signed [33:0] sum;
  reg [15:0] clamped;
  reg [15:0] next_result;

  // scale, offset (4x weight unsigned, 1x signed), clamp and shift
  always @* begin
    if (HAS_GAIN != 0)
      product = ({16'h0000, rawSample & `CONV_MASK} * {16'h0000, gain}) >> `GAIN_FRAC_BITS;
    else
      product = {16'h0000, rawSample & `CONV_MASK};
    if (SIGNED_RESULT != 0) begin
      sum = $signed({{18{rawSample[15]}}, rawSample & `CONV_MASK}) + $signed({{18{offset[15]}}, offset});
      if (sum > $signed({18'h00000, `TEMP_MAX}))
        clamped = `TEMP_MAX;
      else if (sum < $signed({18'h3ffff, `TEMP_MIN}))
        clamped = `TEMP_MIN;
      else
        clamped = sum[15:0];
    end else begin
      sum = $signed({2'b00, product}) + $signed({{16{offset[15]}}, offset, 2'b00});
      if (sum < 34'sh0)
        clamped = 16'h0000;
      else if (sum > $signed({17'h00000, `RESULT_MAX}))
        clamped = `RESULT_CLAMP;
      else
        clamped = sum[15:0];
    end
    if (HAS_SHIFT != 0)
      next_result = clamped >> rightShift; // zero fill keeps it unsigned
    else
      next_result = clamped;
  end

  // register the result on each sample
  always @(posedge clk) begin
    if (!resetn) begin
      result <= 16'h0000;
      resultValid <= 1'b0;
    end else begin
      resultValid <= sampleValid;
      if (sampleValid)
        result <= next_result;
    end
  end

endmodule

//--- verilog/limit_checker.v
/*
 * window comparison of one result against high and low limits, with
 * sticky warning and alarm flags, mask and clear-on-read.
 * assumes read strobes are one clock wide.
 */
`timescale 1ns/1ps
`include "monitor_cal_defs.vh"

module limit_checker #(
  parameter SIGNED_CMP = 0
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // value under test
  input wire valueValid,
  input wire [15:0] value,
  // limits
  input wire [15:0] alarmHigh,
  input wire [15:0] alarmLow,
  input wire [15:0] warnHigh,
  input wire [15:0] warnLow,
  // masks and read-clear
  input wire alarmMask,
  input wire warnMask,
  input wire flagRead,
  // flags
  output reg alarmFlag,
  output reg warnFlag
);

  wire aHi;
  wire aLo;
  wire wHi;
  wire wLo;

  // signed or unsigned compare
  assign aHi = SIGNED_CMP ? ($signed(value) > $signed(alarmHigh)) : (value > alarmHigh);
  assign aLo = SIGNED_CMP ? ($signed(value) < $signed(alarmLow)) : (value < alarmLow);
  assign wHi = SIGNED_CMP ? ($signed(value) > $signed(warnHigh)) : (value > warnHigh);
  assign wLo = SIGNED_CMP ? ($signed(value) < $signed(warnLow)) : (value < warnLow);

  // sticky flags, set wins over the read clear
  always @(posedge clk) begin
    if (!resetn) begin
      alarmFlag <= 1'b0;
      warnFlag <= 1'b0;
    end else begin
      if (valueValid && (aHi || aLo) && !alarmMask)
        alarmFlag <= 1'b1;
      else if (flagRead)
        alarmFlag <= 1'b0;
      if (valueValid && (wHi || wLo) && !warnMask)
        warnFlag <= 1'b1;
      else if (flagRead)
        warnFlag <= 1'b0;
    end
  end

endmodule

//--- verilog/monitor_calibration_alarm_logic.v
/*
 * monitor calibration and alarm logic: seven channel calibration paths,
 * result registers, window flags and interrupt for the diagnostic
 * channels, auxiliary unit classification, and the laser safety trip.
 * assumes converter samples arrive one channel at a time with a valid
 * pulse from logic on the same clock; the host reaches everything here
 * through plain ports driven by its own serial-bus slave.
 */
// Notes on behaviour
// - aux code 0 unused, code 2 reserved
// - code 1 bias volts, code 3 cooler current
// - code 4 laser temperature, code 5 wavelength
// - codes 6 to 9 supply voltages
// - codes 10, 13-15 supply currents
// - flags compared and set automatically
// - unmasked flag raises the interrupt
// - laser trip gates laser, kills drives
// - received and bias channels 38.147uV weight
// - supply and aux unsigned, 100uV weight
// - temperature two's complement, 1/256 degree
// - temperature word over 256 gives degrees
// - per-channel gain and offset; temperature offset only
// - shift only on five channels
// - nonzero shift applied before storing result
// - 13-bit left-justified result, three shifts lossless
// - flags latch until read clears them
// - mask bit blocks flag setting
`timescale 1ns/1ps
`include "monitor_cal_defs.vh"

module monitor_calibration_alarm_logic (
  // clock and reset
  input wire clk,
  input wire resetn,
  // converter sample stream
  input wire sampleValid,
  input wire [2:0] sampleChannel,
  input wire [15:0] sampleData,
  // per-channel calibration, packed by channel index
  input wire [16*`NUM_CH-1:0] gainSetting,
  input wire [16*`NUM_CH-1:0] offsetSetting,
  input wire [3*`NUM_CH-1:0] shiftSetting,
  // auxiliary unit codes
  input wire [3:0] auxUnitOne,
  input wire [3:0] auxUnitTwo,
  // thresholds for the flagged channels 0..5
  input wire [16*`NUM_FLAGGED-1:0] alarmHighLimit,
  input wire [16*`NUM_FLAGGED-1:0] alarmLowLimit,
  input wire [16*`NUM_FLAGGED-1:0] warnHighLimit,
  input wire [16*`NUM_FLAGGED-1:0] warnLowLimit,
  input wire [`NUM_FLAGGED-1:0] alarmMask,
  input wire [`NUM_FLAGGED-1:0] warnMask,
  input wire [`NUM_FLAGGED-1:0] interruptMask,
  input wire flagRead,
  // safety trip settings
  input wire [15:0] bmdTripHigh,
  input wire [15:0] bmdTripLow,
  input wire [15:0] biasDriveTrip,
  input wire [15:0] biasDriveLevel,
  input wire [2:0] safetyMask,
  input wire safetyClear,
  // laser drive requests
  input wire [7:0] biasDriveRequest,
  input wire [7:0] modulationDriveRequest,
  // results
  output reg [16*`NUM_CH-1:0] channelResult,
  output reg [`NUM_FLAGGED-1:0] alarmFlags,
  output reg [`NUM_FLAGGED-1:0] warnFlags,
  output reg [2:0] auxClassOne,
  output reg [2:0] auxClassTwo,
  output reg interruptOut,
  // laser safety
  output reg [2:0] safetyFlags,
  output reg laser_gate_output,
  output reg [7:0] bias_current_drive,
  output reg [7:0] modulation_current_drive
);

  // per-channel sample strobes and calibrated values
  wire [`NUM_CH-1:0] chanStrobe;
  wire [`NUM_CH-1:0] calValid;
  wire [16*`NUM_CH-1:0] calResult;
  wire [`NUM_FLAGGED-1:0] rawAlarm;
  wire [`NUM_FLAGGED-1:0] rawWarn;
  wire [`NUM_FLAGGED-1:0] auxInUse;
  reg [2:0] next_classOne;
  reg [2:0] next_classTwo;
  reg [2:0] tripNow;
  reg tripped;
  genvar ch;

  // classify a unit code
  function [2:0] unitClass;
    input [3:0] code;
    begin
      case (code)
        `UNIT_UNUSED: unitClass = `CLASS_UNUSED;
        `UNIT_PD_BIAS: unitClass = `CLASS_VOLT_10MV;
        `UNIT_RESERVED: unitClass = `CLASS_INVALID;
        `UNIT_COOLER_I: unitClass = `CLASS_CURR_100UA;
        `UNIT_LASER_TEMP: unitClass = `CLASS_TEMP;
        `UNIT_WAVELENGTH: unitClass = `CLASS_WAVELENGTH;
        `UNIT_SUPPLY_I_FIRST: unitClass = `CLASS_CURR_100UA;
        `UNIT_SUPPLY_I_GAP_LO: unitClass = `CLASS_INVALID;
        `UNIT_SUPPLY_I_GAP_HI: unitClass = `CLASS_INVALID;
        default: begin
          if (code >= `UNIT_SUPPLY_V_FIRST && code <= `UNIT_SUPPLY_V_LAST)
            unitClass = `CLASS_SUPPLY_V;
          else
            unitClass = `CLASS_CURR_100UA;
        end
      endcase
    end
  endfunction

  // unit class decode
  always @* begin
    next_classOne = unitClass(auxUnitOne);
    next_classTwo = unitClass(auxUnitTwo);
  end

  // an unused aux channel raises no flags
  assign auxInUse = {auxUnitTwo != `UNIT_UNUSED, auxUnitOne != `UNIT_UNUSED, 4'hf};

  // sample strobe per channel
  generate
    for (ch = 0; ch < `NUM_CH; ch = ch + 1) begin : strobePath
      assign chanStrobe[ch] = sampleValid && (sampleChannel == ch);
    end
  endgenerate

  // temperature path, offset only and signed
  channel_calibrator #(
    .HAS_GAIN(0), // temperature offset only
    .HAS_SHIFT(0), // no shift on temperature
    .SIGNED_RESULT(1) // two's complement temperature
  ) calTemp (
    .clk(clk),
    .resetn(resetn),
    .sampleValid(chanStrobe[`CH_TEMP]),
    .rawSample(sampleData),
    .gain(gainSetting[16*`CH_TEMP +: 16]),
    .offset(offsetSetting[16*`CH_TEMP +: 16]),
    .rightShift(shiftSetting[3*`CH_TEMP +: 3]),
    .resultValid(calValid[`CH_TEMP]),
    .result(calResult[16*`CH_TEMP +: 16])
  );

  // supply path, gain and offset, no shift
  channel_calibrator #(
    .HAS_GAIN(1),
    .HAS_SHIFT(0), // no shift on supply
    .SIGNED_RESULT(0)
  ) calSupply (
    .clk(clk),
    .resetn(resetn),
    .sampleValid(chanStrobe[`CH_SUPPLY]),
    .rawSample(sampleData),
    .gain(gainSetting[16*`CH_SUPPLY +: 16]),
    .offset(offsetSetting[16*`CH_SUPPLY +: 16]),
    .rightShift(shiftSetting[3*`CH_SUPPLY +: 3]),
    .resultValid(calValid[`CH_SUPPLY]),
    .result(calResult[16*`CH_SUPPLY +: 16])
  );

  // bias monitor path
  channel_calibrator #(
    .HAS_GAIN(1),
    .HAS_SHIFT(1),
    .SIGNED_RESULT(0)
  ) calBiasMon (
    .clk(clk),
    .resetn(resetn),
    .sampleValid(chanStrobe[`CH_BIASMON]),
    .rawSample(sampleData),
    .gain(gainSetting[16*`CH_BIASMON +: 16]),
    .offset(offsetSetting[16*`CH_BIASMON +: 16]),
    .rightShift(shiftSetting[3*`CH_BIASMON +: 3]),
    .resultValid(calValid[`CH_BIASMON]),
    .result(calResult[16*`CH_BIASMON +: 16])
  );

  // received strength path
  channel_calibrator #(
    .HAS_GAIN(1),
    .HAS_SHIFT(1),
    .SIGNED_RESULT(0)
  ) calRxStr (
    .clk(clk),
    .resetn(resetn),
    .sampleValid(chanStrobe[`CH_RXSTR]),
    .rawSample(sampleData),
    .gain(gainSetting[16*`CH_RXSTR +: 16]),
    .offset(offsetSetting[16*`CH_RXSTR +: 16]),
    .rightShift(shiftSetting[3*`CH_RXSTR +: 3]),
    .resultValid(calValid[`CH_RXSTR]),
    .result(calResult[16*`CH_RXSTR +: 16])
  );

  // first auxiliary path
  channel_calibrator #(
    .HAS_GAIN(1),
    .HAS_SHIFT(1),
    .SIGNED_RESULT(0)
  ) calAuxOne (
    .clk(clk),
    .resetn(resetn),
    .sampleValid(chanStrobe[`CH_AUX1]),
    .rawSample(sampleData),
    .gain(gainSetting[16*`CH_AUX1 +: 16]),
    .offset(offsetSetting[16*`CH_AUX1 +: 16]),
    .rightShift(shiftSetting[3*`CH_AUX1 +: 3]),
    .resultValid(calValid[`CH_AUX1]),
    .result(calResult[16*`CH_AUX1 +: 16])
  );

  // second auxiliary path
  channel_calibrator #(
    .HAS_GAIN(1),
    .HAS_SHIFT(1),
    .SIGNED_RESULT(0)
  ) calAuxTwo (
    .clk(clk),
    .resetn(resetn),
    .sampleValid(chanStrobe[`CH_AUX2]),
    .rawSample(sampleData),
    .gain(gainSetting[16*`CH_AUX2 +: 16]),
    .offset(offsetSetting[16*`CH_AUX2 +: 16]),
    .rightShift(shiftSetting[3*`CH_AUX2 +: 3]),
    .resultValid(calValid[`CH_AUX2]),
    .result(calResult[16*`CH_AUX2 +: 16])
  );

  // back monitor diode path, feeds the safety trip
  channel_calibrator #(
    .HAS_GAIN(1),
    .HAS_SHIFT(1),
    .SIGNED_RESULT(0)
  ) calBackMon (
    .clk(clk),
    .resetn(resetn),
    .sampleValid(chanStrobe[`CH_BMD]),
    .rawSample(sampleData),
    .gain(gainSetting[16*`CH_BMD +: 16]),
    .offset(offsetSetting[16*`CH_BMD +: 16]),
    .rightShift(shiftSetting[3*`CH_BMD +: 3]),
    .resultValid(calValid[`CH_BMD]),
    .result(calResult[16*`CH_BMD +: 16])
  );

  // window flags for temperature, supply, bias monitor, received, aux
  generate
    for (ch = 0; ch < `NUM_FLAGGED; ch = ch + 1) begin : flagPath
      limit_checker #(
        .SIGNED_CMP(ch == 0)
      ) chkInst (
        .clk(clk),
        .resetn(resetn),
        .valueValid(calValid[ch] && auxInUse[ch]),
        .value(calResult[16*ch +: 16]),
        .alarmHigh(alarmHighLimit[16*ch +: 16]),
        .alarmLow(alarmLowLimit[16*ch +: 16]),
        .warnHigh(warnHighLimit[16*ch +: 16]),
        .warnLow(warnLowLimit[16*ch +: 16]),
        .alarmMask(alarmMask[ch]),
        .warnMask(warnMask[ch]),
        .flagRead(flagRead),
        .alarmFlag(rawAlarm[ch]),
        .warnFlag(rawWarn[ch])
      );
    end
  endgenerate

  // result registers hold the stored calibrated values
  integer k;
  always @(posedge clk) begin
    if (!resetn) begin
      channelResult <= {16*`NUM_CH{1'b0}};
    end else begin
      for (k = 0; k < `NUM_CH; k = k + 1) begin
        if (calValid[k])
          channelResult[16*k +: 16] <= calResult[16*k +: 16];
      end
    end
  end

  // flag, class and interrupt registers
  always @(posedge clk) begin
    if (!resetn) begin
      alarmFlags <= {`NUM_FLAGGED{1'b0}};
      warnFlags <= {`NUM_FLAGGED{1'b0}};
      auxClassOne <= `CLASS_UNUSED;
      auxClassTwo <= `CLASS_UNUSED;
      interruptOut <= 1'b0;
    end else begin
      alarmFlags <= rawAlarm;
      warnFlags <= rawWarn;
      auxClassOne <= next_classOne;
      auxClassTwo <= next_classTwo;
      interruptOut <= |((rawAlarm | rawWarn) & ~interruptMask); // mask 0 lets it through
    end
  end

  // safety trip compare on back monitor and bias drive
  always @* begin
    tripNow[0] = calValid[`CH_BMD] && (calResult[16*`CH_BMD +: 16] > bmdTripHigh) && !safetyMask[0];
    tripNow[1] = calValid[`CH_BMD] && (calResult[16*`CH_BMD +: 16] < bmdTripLow) && !safetyMask[1];
    tripNow[2] = (biasDriveLevel > biasDriveTrip) && !safetyMask[2];
  end

  // latched safety fault gates the laser and shuts the drives
  always @(posedge clk) begin
    if (!resetn) begin
      safetyFlags <= 3'h0;
      tripped <= 1'b0;
      laser_gate_output <= 1'b0;
      bias_current_drive <= 8'h00;
      modulation_current_drive <= 8'h00;
    end else begin
      if (|tripNow) begin
        safetyFlags <= safetyFlags | tripNow;
        tripped <= 1'b1;
        laser_gate_output <= 1'b1;
        bias_current_drive <= 8'h00;
        modulation_current_drive <= 8'h00;
      end else if (safetyClear) begin
        safetyFlags <= 3'h0;
        tripped <= 1'b0;
        laser_gate_output <= 1'b0;
        bias_current_drive <= 8'h00;
        modulation_current_drive <= 8'h00;
      end else if (tripped) begin
        bias_current_drive <= 8'h00;
        modulation_current_drive <= 8'h00;
      end else begin
        bias_current_drive <= biasDriveRequest;
        modulation_current_drive <= modulationDriveRequest;
      end
    end
  end

endmodule

//--- tb/monitor_cal_props.sv
/*
 * concurrent checks on the monitor calibration and alarm block ports.
 * assumes binding onto the block top; one clock, synchronous active-low reset.
 */
`timescale 1ns/1ps
module monitor_cal_props (
  // clock and reset
  input wire clk,
  input wire resetn,
  // stimulus seen
  input wire sampleValid,
  input wire [2:0] sampleChannel,
  input wire [15:0] sampleData,
  input wire [111:0] gainSetting,
  input wire [111:0] offsetSetting,
  input wire [20:0] shiftSetting,
  input wire [3:0] auxUnitOne,
  input wire [5:0] alarmMask,
  input wire [5:0] interruptMask,
  input wire flagRead,
  input wire [15:0] biasDriveTrip,
  input wire [15:0] biasDriveLevel,
  input wire [2:0] safetyMask,
  input wire safetyClear,
  input wire [7:0] biasDriveRequest,
  // outputs watched
  input wire [111:0] channelResult,
  input wire [5:0] alarmFlags,
  input wire [5:0] warnFlags,
  input wire [2:0] auxClassOne,
  input wire interruptOut,
  input wire laser_gate_output,
  input wire [7:0] bias_current_drive,
  input wire [7:0] modulation_current_drive
);
  // unit class per code, one nibble per code
  localparam [63:0] CLASS_MAP = 64'h2226_6255_5543_2610;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // class follows a settled code
  aux_class_map_a:
    assert property ($past(resetn) && $stable(auxUnitOne) |-> auxClassOne == CLASS_MAP[4*auxUnitOne +: 3])
    else $error("aux class wrong");
  supply_unit_gain_a:
    assert property (sampleValid && sampleChannel == 3'h1 && gainSetting[31:16] == 16'h8000
      && offsetSetting[31:16] == 16'h0 |-> ##2 channelResult[31:16] == ($past(sampleData, 2) & 16'hfff8))
    else $error("supply result wrong");
  shift_zero_fill_a:
    assert property (sampleValid && sampleChannel == 3'h2 && gainSetting[47:32] == 16'h8000
      && offsetSetting[47:32] == 16'h0
      |-> ##2 channelResult[47:32] == (($past(sampleData, 2) & 16'hfff8) >> $past(shiftSetting[8:6], 2)))
    else $error("shifted result wrong");
  mask_blocks_a:
    assert property ((alarmFlags & ~$past(alarmFlags) & $past(alarmMask) & $past(alarmMask, 2)
      & $past(alarmMask, 3)) == 6'h0)
    else $error("masked flag rose");
  flag_sticky_a:
    assert property ($past(resetn) && |($past(alarmFlags | warnFlags) & ~(alarmFlags | warnFlags))
      |-> $past(flagRead) || $past(flagRead, 2) || $past(flagRead, 3))
    else $error("flag fell without read");
  irq_level_a:
    assert property ($past(resetn) && $stable(interruptMask)
      |-> interruptOut == |((alarmFlags | warnFlags) & ~interruptMask))
    else $error("interrupt level wrong");
  gate_kills_a:
    assert property (laser_gate_output |-> bias_current_drive == 8'h0 && modulation_current_drive == 8'h0)
    else $error("drive on while gated");
  drive_follows_a:
    assert property ($past(resetn) && !laser_gate_output && !$past(laser_gate_output)
      |-> bias_current_drive == $past(biasDriveRequest))
    else $error("drive not following");
  bias_trip_a:
    assert property (biasDriveLevel > biasDriveTrip && !safetyMask[2] |-> ##1 laser_gate_output)
    else $error("bias trip missed");
  gate_latched_a:
    assert property ($past(resetn) && $fell(laser_gate_output) |-> $past(safetyClear))
    else $error("gate dropped alone");
endmodule

bind monitor_calibration_alarm_logic monitor_cal_props i_props (.*);

//--- tb/converter_model.sv
/*
 * converter model: hands one raw sample at a time to the block.
 * assumes the bench calls convert from its main sequence.
 */
`timescale 1ns/1ps
module converter_model (
  // clock
  input wire clk,
  // sample stream
  output reg sampleValid,
  output reg [2:0] sampleChannel,
  output reg [15:0] sampleData
);
  // idle stream at time zero
  initial begin
    sampleValid = 1'b0;
    sampleChannel = 3'h0;
    sampleData = 16'h0;
  end

  // one-cycle pulse; bus shows inverse once released
  task convert(input [2:0] ch, input [15:0] code);
    begin
      @(posedge clk);
      #1 sampleValid = 1'b1;
      sampleChannel = ch;
      sampleData = {code[15:3], 3'h5}; // noise below the 13 bits
      @(posedge clk);
      #1 sampleValid = 1'b0;
      sampleChannel = ~ch;
      sampleData = ~sampleData;
    end
  endtask
endmodule

//--- tb/monitor_calibration_alarm_logic_test.sv
/*
 * self-checking bench for the monitor calibration and alarm block.
 * assumes the converter model drives samples and the checker is bound.
 */
`timescale 1ns/1ps
module monitor_calibration_alarm_logic_test;
  // settings and stimulus
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg [111:0] gainSetting = {7{16'h8000}};
  reg [111:0] offsetSetting = 112'h0;
  reg [20:0] shiftSetting = 21'h0;
  reg [3:0] auxUnitOne = 4'h1;
  reg [3:0] auxUnitTwo = 4'h1;
  reg [95:0] alarmHighLimit = {{5{16'hf000}}, 16'h7ff8};
  reg [95:0] alarmLowLimit = {80'h0, 16'h8800};
  reg [95:0] warnHighLimit = {{5{16'he000}}, 16'h7ff8};
  reg [95:0] warnLowLimit = {80'h0, 16'h8800};
  reg [5:0] alarmMask = 6'h0;
  reg [5:0] warnMask = 6'h0;
  reg [5:0] interruptMask = 6'h0;
  reg flagRead = 1'b0;
  reg [15:0] bmdTripHigh = 16'hffff;
  reg [15:0] bmdTripLow = 16'h0;
  reg [15:0] biasDriveTrip = 16'h8000;
  reg [15:0] biasDriveLevel = 16'h1000;
  reg [2:0] safetyMask = 3'h0;
  reg safetyClear = 1'b0;
  reg [7:0] biasDriveRequest = 8'h5a;
  reg [7:0] modulationDriveRequest = 8'ha5;
  // outputs
  wire sampleValid;
  wire [2:0] sampleChannel;
  wire [15:0] sampleData;
  wire [111:0] channelResult;
  wire [5:0] alarmFlags, warnFlags;
  wire [2:0] auxClassOne, auxClassTwo, safetyFlags;
  wire interruptOut, laser_gate_output;
  wire [7:0] bias_current_drive, modulation_current_drive;
  // bookkeeping
  localparam [63:0] CLASS_MAP = 64'h2226_6255_5543_2610;
  integer fail_count = 0;
  integer num_checks = 0;
  integer i;
  reg [2:0] ch, s;
  reg [15:0] raw, g, o;
  reg [15:0] trialGain, highReading, null_reading;
  localparam [15:0] null_expected_count = 16'h0c00;
  localparam [15:0] high_expected_count = 16'hf000;
  // rows of {channel, raw, gain, offset, shift}
  reg [53:0] rows [0:7] = '{
    {3'h1, 16'h4007, 16'h8000, 16'h0000, 3'h0}, {3'h1, 16'h8000, 16'hffff, 16'h0000, 3'h0},
    {3'h2, 16'hffff, 16'h8000, 16'h0000, 3'h3}, {3'h3, 16'h1000, 16'h4000, 16'hfffe, 3'h1},
    {3'h4, 16'h0008, 16'h8000, 16'hff00, 3'h0}, {3'h6, 16'h2000, 16'hc000, 16'h0010, 3'h2},
    {3'h1, 16'h2000, 16'h8000, 16'h0000, 3'h7}, {3'h5, 16'h1230, 16'h8000, 16'h0001, 3'h0}};

  monitor_calibration_alarm_logic i_dut (.*);
  converter_model i_adc (.*);

  // 20 MHz clock
  always #25 clk = ~clk;

  // compare and count
  task check(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // gain, offset times four, clamp, zero-filled shift
  function [15:0] calc(input [15:0] r, input [15:0] gn, input [15:0] of, input [2:0] sh);
    reg signed [33:0] v;
    begin
      v = (({18'h0, r & 16'hfff8} * gn) >> 15) + 4 * $signed({{18{of[15]}}, of});
      if (v < 0) v = 0;
      if (v > 34'sh0fff8) v = 34'sh0fff8;
      calc = v[15:0] >> sh;
    end
  endfunction

  // host read of the flag location
  task pulse_read;
    begin
      @(posedge clk);
      #1 flagRead = 1'b1;
      @(posedge clk);
      #1 flagRead = 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  task report_and_stop;
    begin
      if (fail_count == 0 && num_checks > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask

  // watchdog
  initial begin
    #200000;
    fail_count = fail_count + 1;
    report_and_stop;
  end

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      {ch, raw, g, o, s} = rows[i];
      gainSetting[16*ch +: 16] = g;
      offsetSetting[16*ch +: 16] = o;
      shiftSetting[3*ch +: 3] = s;
      i_adc.convert(ch, raw);
      repeat (2) @(posedge clk);
      #1 check(channelResult[16*ch +: 16], calc(raw, g, o, ch > 3'h1 ? s : 3'h0));
    end
    // temperature: offset only, signed clamp
    gainSetting[15:0] = 16'h0;
    offsetSetting[15:0] = 16'h0100;
    i_adc.convert(3'h0, 16'hf600);
    repeat (2) @(posedge clk);
    #1 check(channelResult[15:0], 16'hf700);
    i_adc.convert(3'h0, 16'h8000);
    repeat (2) @(posedge clk);
    #1 check(channelResult[15:0], 16'h8800);
    // host offset from a null reading
    gainSetting[63:48] = 16'h8000;
    offsetSetting[63:48] = 16'h0;
    shiftSetting[11:9] = 3'h0;
    i_adc.convert(3'h3, 16'h0100);
    repeat (2) @(posedge clk);
    #1 offsetSetting[63:48] = -(channelResult[63:48] >> 2);
    i_adc.convert(3'h3, 16'h0100);
    repeat (2) @(posedge clk);
    #1 check(channelResult[63:48], 16'h0);
    // host gain search on the received channel
    offsetSetting[63:48] = 16'h0;
    trialGain = 16'h0;
    for (i = 15; i >= 0; i = i - 1) begin
      trialGain[i] = 1'b1;
      gainSetting[63:48] = trialGain;
      i_adc.convert(3'h3, 16'ha000);
      repeat (2) @(posedge clk);
      #1 highReading = channelResult[63:48];
      if (highReading >= 16'hfff8) begin
        trialGain[i] = 1'b0;
      end else begin
        i_adc.convert(3'h3, 16'h0800);
        repeat (2) @(posedge clk);
        #1 null_reading = channelResult[63:48];
        if (highReading - null_reading > high_expected_count - null_expected_count)
          trialGain[i] = 1'b0;
      end
    end
    check(trialGain, 16'hc000);
    for (i = 0; i < 16; i = i + 1) begin
      auxUnitOne = i[3:0];
      auxUnitTwo = 4'hf - i[3:0];
      repeat (2) @(posedge clk);
      #1 check(auxClassOne, CLASS_MAP[4*i +: 3]);
      check(auxClassTwo, CLASS_MAP[4*(15-i) +: 3]);
    end
    // window flags, interrupt, masks
    pulse_read;
    check({alarmFlags, warnFlags}, 12'h0);
    i_adc.convert(3'h1, 16'he800);
    repeat (3) @(posedge clk);
    #1 check({alarmFlags, warnFlags, interruptOut}, 13'h005);
    i_adc.convert(3'h1, 16'h1000);
    interruptMask = 6'h02;
    i_adc.convert(3'h5, 16'hf800);
    repeat (3) @(posedge clk);
    #1 check({alarmFlags, warnFlags, interruptOut}, 13'h004);
    pulse_read;
    check(warnFlags, 6'h0);
    {alarmMask, warnMask} = 12'h082;
    i_adc.convert(3'h1, 16'hffff);
    repeat (3) @(posedge clk);
    #1 check({alarmFlags, warnFlags}, 12'h0);
    alarmMask = 6'h0;
    alarmLowLimit[31:16] = 16'h0400;
    i_adc.convert(3'h1, 16'h0100);
    repeat (3) @(posedge clk);
    #1 check({alarmFlags, warnFlags}, 12'h080);
    // safety trips
    safetyMask = 3'h4;
    biasDriveLevel = 16'h9000;
    repeat (3) @(posedge clk);
    #1 check({laser_gate_output, bias_current_drive}, 9'h05a);
    safetyMask = 3'h0;
    repeat (2) @(posedge clk);
    #1 check({laser_gate_output, bias_current_drive, modulation_current_drive}, 17'h10000);
    check(safetyFlags, 3'h4);
    biasDriveLevel = 16'h1000;
    safetyClear = 1'b1;
    @(posedge clk);
    #1 safetyClear = 1'b0;
    repeat (2) @(posedge clk);
    #1 check({laser_gate_output, modulation_current_drive}, 9'h0a5);
    bmdTripHigh = 16'h8000;
    {gainSetting[111:96], offsetSetting[111:96], shiftSetting[20:18]} = {16'h8000, 16'h0, 3'h0};
    i_adc.convert(3'h6, 16'hf000);
    repeat (2) @(posedge clk);
    #1 check({laser_gate_output, bias_current_drive}, 9'h100);
    check(safetyFlags, 3'h1);
    // low trip on the back monitor
    safetyClear = 1'b1;
    bmdTripHigh = 16'hffff;
    bmdTripLow = 16'h1000;
    @(posedge clk);
    #1 safetyClear = 1'b0;
    i_adc.convert(3'h6, 16'h0800);
    repeat (2) @(posedge clk);
    #1 check({laser_gate_output, safetyFlags}, 4'ha);
    // second reset clears everything
    resetn = 1'b0;
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    check({|channelResult, laser_gate_output, |alarmFlags, |warnFlags, interruptOut}, 5'h0);
    report_and_stop;
  end
endmodule
